// File: design/bcs_defs.vh
// Constants for the blit control sequencer
`ifndef BCS_DEFS_VH
`define BCS_DEFS_VH
// Register indices
`define BCS_IDX_CTRL1 4'h0
`define BCS_IDX_CTRL2 4'h1
`define BCS_IDX_SRC_LO 4'h2
`define BCS_IDX_SRC_HI 4'h3
`define BCS_IDX_DST_LO 4'h4
`define BCS_IDX_DST_HI 4'h5
`define BCS_IDX_DIM_X 4'h6
`define BCS_IDX_DIM_Y 4'h7
`define BCS_IDX_PITCH 4'h8
`define BCS_IDX_LAST 4'he
// Control word 1 fields
`define BCS_C1_ACT 11
`define BCS_C1_DLIN 7
// Control word 2 fields
`define BCS_C2_LINE 11
`define BCS_C2_IRQ_EN 10
`define BCS_C2_YMAJ 9
`define BCS_C2_YDIR 8
`define BCS_C2_QUICK 7
`define BCS_C2_UPD 6
`define BCS_C2_PAT_HI 5
`define BCS_C2_PAT_LO 4
`define BCS_C2_MONO_TR 3
`define BCS_C2_TR_POL 2
`define BCS_C2_TR_SRC 1
`define BCS_C2_TR_EN 0
// Reset values
`define BCS_RST_WORD 16'h0000
// Abort drain count in system clocks; the abort is held for at most one clock more than this
`define BCS_ABORT_CYC 4'h3
`endif

// File: design/bcs_index_port.v
// Index pointer for the register access port
`timescale 1ns/1ps
module bcs_index_port (
  // Clock and reset
  input wire clk_sys_in,
  input wire rst_n_in,
  // Host side
  input wire idx_wr_in,
  input wire [3:0] idx_data_in,
  input wire ainc_dis_in,
  input wire rd_in,
  // Current index
  output reg [3:0] idx_out
);
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      idx_out <= 4'h0;
    end else if (idx_wr_in) begin
      idx_out <= idx_data_in;
    end else if (rd_in && !ainc_dis_in) begin
      idx_out <= idx_out + 4'h1;
    end
  end
endmodule // bcs_index_port

// File: design/bcs_dest_adv.v
// Destination advance arithmetic
`timescale 1ns/1ps
module bcs_dest_adv (
  // Operands
  input wire [31:0] dst_in,
  input wire [15:0] dim_x_in,
  input wire [15:0] dim_y_in,
  input wire [15:0] pitch_in,
  input wire linear_in,
  // Result
  output reg [31:0] dst_out
);
  always @* begin
    if (linear_in) begin
      dst_out = dst_in + {16'h0000, dim_x_in} * {16'h0000, dim_y_in};
    end else begin
      dst_out = dst_in + {16'h0000, dim_x_in};
    end
  end
  // Pitch kept for future line-span variants
  wire unused_pitch;
  assign unused_pitch = |pitch_in;
endmodule // bcs_dest_adv

// File: design/bcs_top.v
// Blit engine control and indexed register file
`timescale 1ns/1ps
`include "bcs_defs.vh"
module bcs_top (
  // Clock and reset
  input wire clk_sys_in,
  input wire rst_n_in,
  // Host port: index (low port) and data (high port)
  input wire idx_wr_in,
  input wire [3:0] idx_data_in,
  input wire ainc_dis_in,
  input wire data_wr_in,
  input wire data_rd_in,
  input wire [15:0] wdata_in,
  output reg [15:0] rdata_out,
  // Engine side
  input wire eng_done_in,
  input wire eng_stopped_in,
  output reg eng_start_out,
  output reg eng_run_out,
  output reg eng_abort_out,
  // Mode outputs to the datapath
  output reg line_mode_out,
  output reg y_major_out,
  output reg y_up_out,
  output reg [1:0] pat_sel_out,
  output reg mono_tr_out,
  output reg tr_opaque_out,
  output reg tr_src_out,
  output reg tr_en_out,
  output reg irq_out
);
  // ****************************************
  // Registers
  // ****************************************
  // One-hot run states
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_RUN = 3'b010;
  localparam [2:0] ST_DRAIN = 3'b100;

  // Slot F is not stored; reads of it return zero
  reg [15:0] regs_q [0:14];
  wire [3:0] idx;
  wire [31:0] dst_next;
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [3:0] abort_cnt_q;
  reg [3:0] abort_cnt_d;
  reg start_d;
  reg irq_d;
  wire busy;
  wire done_ok;
  wire [15:0] c1;
  wire [15:0] c2;
  wire wr_ctrl1;
  wire wr_dlo;
  wire wr_slo;
  wire quick_go;
  wire host_clr_act;
  wire host_set_act;
  wire go_req;
  integer i;

  // Register index match, shared by every write decode
  function idx_hit;
    input [3:0] cur;
    input [3:0] want;
    begin
      idx_hit = (cur == want);
    end
  endfunction

  // Index F has no storage behind it
  function idx_valid;
    input [3:0] cur;
    begin
      idx_valid = (cur <= `BCS_IDX_LAST);
    end
  endfunction

  // Reserved codes fall back to no pattern, so a stray write
  // cannot select an undefined source
  function [1:0] pat_decode;
    input [1:0] code;
    begin
      pat_decode = (code == 2'h1) ? 2'h1 : 2'h0;
    end
  endfunction

  assign c1 = regs_q[`BCS_IDX_CTRL1];
  assign c2 = regs_q[`BCS_IDX_CTRL2];
  assign busy = (state_q == ST_RUN);

  // Index pointer with auto-increment
  bcs_index_port u_idx (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .idx_wr_in(idx_wr_in),
    .idx_data_in(idx_data_in),
    .ainc_dis_in(ainc_dis_in),
    .rd_in(data_rd_in),
    .idx_out(idx)
  );

  bcs_dest_adv u_adv (
    .dst_in({regs_q[5], regs_q[4]}),
    .dim_x_in(regs_q[6]),
    .dim_y_in(regs_q[7]),
    .pitch_in(regs_q[8]),
    .linear_in(c1[`BCS_C1_DLIN]),
    .dst_out(dst_next)
  );

  // ****************************************
  // Write decode
  // ****************************************
  assign wr_ctrl1 = data_wr_in && idx_hit(idx, `BCS_IDX_CTRL1);
  assign wr_dlo = data_wr_in && idx_hit(idx, `BCS_IDX_DST_LO);
  assign wr_slo = data_wr_in && idx_hit(idx, `BCS_IDX_SRC_LO);
  // quick start trigger select
  // Source low is the last write of a chained copy when the
  // destination advances by itself
  assign quick_go = c2[`BCS_C2_QUICK] &&
    (c2[`BCS_C2_UPD] ? wr_slo : wr_dlo);
  assign host_clr_act = wr_ctrl1 && !wdata_in[`BCS_C1_ACT];
  assign host_set_act = wr_ctrl1 && wdata_in[`BCS_C1_ACT];
  assign go_req = host_set_act || quick_go;

  // ****************************************
  // Completion
  // ****************************************
  // Counts only while the activation bit still stands; an abort written
  // in the done cycle is not yet seen there, so the destination still advances
  assign done_ok = busy && eng_done_in && c1[`BCS_C1_ACT];

  // ****************************************
  // Register file
  // ****************************************
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (i = 0; i < 15; i = i + 1) begin
        regs_q[i] <= `BCS_RST_WORD;
      end
    end else begin
      if (data_wr_in && idx_valid(idx)) begin
        regs_q[idx] <= wdata_in;
      end
      if (quick_go) begin
        regs_q[0][`BCS_C1_ACT] <= 1'b1;
      end
      if (done_ok) begin
        regs_q[0][`BCS_C1_ACT] <= 1'b0;
        if (c2[`BCS_C2_UPD]) begin
          regs_q[4] <= dst_next[15:0];
          regs_q[5] <= dst_next[31:16];
        end
      end
    end
  end

  // ****************************************
  // Run control
  // ****************************************
  // Next state and one-cycle pulses
  always @* begin
    state_d = state_q;
    abort_cnt_d = abort_cnt_q;
    start_d = 1'b0;
    irq_d = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (go_req) begin
          state_d = ST_RUN;
          start_d = 1'b1;
        end
      end
      ST_RUN: begin
        if (host_clr_act) begin
          state_d = ST_DRAIN;
          abort_cnt_d = `BCS_ABORT_CYC;
        end else if (eng_done_in) begin
          state_d = ST_IDLE;
          irq_d = c2[`BCS_C2_IRQ_EN];
        end
      end
      ST_DRAIN: begin
        // A new start drops the abort at once, else the engine
        // would be stopped again right after its launch
        if (go_req) begin
          state_d = ST_RUN;
          start_d = 1'b1;
        end else if (abort_cnt_q == 4'h0 || eng_stopped_in) begin
          // Abort held a fixed drain time or until the engine idles
          state_d = ST_IDLE;
        end else begin
          abort_cnt_d = abort_cnt_q - 4'h1;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Every engine-facing line comes straight from a flop, so the
  // levels follow the next state rather than the current one
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= ST_IDLE;
      abort_cnt_q <= 4'h0;
      eng_start_out <= 1'b0;
      eng_run_out <= 1'b0;
      eng_abort_out <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      state_q <= state_d;
      abort_cnt_q <= abort_cnt_d;
      eng_start_out <= start_d;
      eng_run_out <= (state_d == ST_RUN);
      eng_abort_out <= (state_d == ST_DRAIN);
      irq_out <= irq_d;
    end
  end

  // ****************************************
  // Mode decode
  // ****************************************
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      line_mode_out <= 1'b0;
      y_major_out <= 1'b0;
      y_up_out <= 1'b0;
      pat_sel_out <= 2'h0;
      mono_tr_out <= 1'b0;
      tr_opaque_out <= 1'b0;
      tr_src_out <= 1'b0;
      tr_en_out <= 1'b0;
    end else begin
      line_mode_out <= c2[`BCS_C2_LINE];
      // Line-only fields are forced low outside line mode so the
      // datapath never acts on a stale axis or direction
      // major axis only for lines
      y_major_out <= c2[`BCS_C2_LINE] & c2[`BCS_C2_YMAJ];
      y_up_out <= c2[`BCS_C2_LINE] & c2[`BCS_C2_YDIR];
      // reserved codes fall back to none
      pat_sel_out <= pat_decode(c2[`BCS_C2_PAT_HI:`BCS_C2_PAT_LO]);
      mono_tr_out <= c2[`BCS_C2_MONO_TR];
      tr_opaque_out <= c2[`BCS_C2_TR_POL];
      tr_src_out <= c2[`BCS_C2_TR_SRC];
      tr_en_out <= c2[`BCS_C2_TR_EN];
    end
  end

  // ****************************************
  // Readback
  // ****************************************
  // One cycle of lag: after an index load the host lets one
  // edge pass before it samples the data port
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= `BCS_RST_WORD;
    end else if (idx_valid(idx)) begin
      rdata_out <= regs_q[idx];
    end else begin
      rdata_out <= 16'h0000;
    end
  end
endmodule // bcs_top

// File: test/bcs_top_assertions.sv
// Port checker for the blit control sequencer
`timescale 1ns/1ps
module bcs_top_assertions (
  // Clock, reset and host strobe
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic data_wr_in,
  // Engine handshake
  input wire logic eng_done_in,
  input wire logic eng_start_out,
  input wire logic eng_run_out,
  input wire logic eng_abort_out,
  input wire logic irq_out,
  // Mode decode
  input wire logic line_mode_out,
  input wire logic y_major_out,
  input wire logic y_up_out,
  input wire logic tr_en_out,
  input wire logic [1:0] pat_sel_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_drain; ##[1:4] !eng_abort_out; endsequence
  AST_START_RUN: assert property (
    eng_start_out |-> eng_run_out ##1 !eng_start_out) else $error("bad start");
  AST_DONE_CLR: assert property (
    eng_done_in && eng_run_out |=> !eng_run_out) else $error("run stuck");
  AST_IRQ_CAUSE: assert property (
    irq_out |-> $past(eng_done_in && eng_run_out) ##1 !irq_out)
    else $error("stray irq");
  AST_ABORT_STOP: assert property (
    $rose(eng_abort_out) |-> !eng_run_out ##0 s_drain) else $error("abort");
  AST_ABORT_CAUSE: assert property (
    $rose(eng_abort_out) |-> $past(eng_run_out && data_wr_in))
    else $error("abort without clear");
  AST_YMAJ_LINE: assert property (
    y_major_out |-> line_mode_out) else $error("major axis outside line");
  AST_YUP_LINE: assert property (
    y_up_out |-> line_mode_out) else $error("direction outside line");
  AST_PAT_RSVD: assert property (
    !pat_sel_out[1]) else $error("reserved pattern code");
  AST_MODE_HOLD: assert property (
    !$past(data_wr_in) && !$past(data_wr_in, 2) |-> $stable({line_mode_out,
    y_major_out, y_up_out, pat_sel_out, tr_en_out})) else $error("mode drift");
endmodule // bcs_top_assertions
bind bcs_top bcs_top_assertions bcs_top_assertions_inst (.clk_sys_in,
  .rst_n_in, .data_wr_in, .eng_done_in, .eng_start_out, .eng_run_out,
  .eng_abort_out, .irq_out, .line_mode_out, .y_major_out, .y_up_out,
  .tr_en_out, .pat_sel_out);

// File: test/bcs_engine_model.sv
// Behavioural engine answering start and abort
`timescale 1ns/1ps
module bcs_engine_model #(parameter int LAT = 20) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // Commands from the block
  input wire logic start_in,
  input wire logic abort_in,
  // Status back to the block
  output logic done_out,
  output logic stopped_out
);
  int cnt_q;
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= 0;
      done_out <= 1'b0;
    end else begin
      done_out <= (cnt_q == 1) && !abort_in;
      if (start_in) cnt_q <= LAT;
      else if (abort_in) cnt_q <= 0;
      else if (cnt_q != 0) cnt_q <= cnt_q - 1;
    end
  end
  assign stopped_out = (cnt_q == 0);
endmodule // bcs_engine_model

// File: test/bcs_top_tb.sv
// Self-checking bench for the blit control sequencer
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin \
  num_errors++; $display("Error %0t: got %h want %h", $time, a, e); end end
module bcs_top_tb;
  logic clk_sys_in = 0, rst_n_in = 0, idx_wr_in = 0, ainc_dis_in = 0;
  logic data_wr_in = 0, data_rd_in = 0;
  logic [3:0] idx_data_in = 4'h0;
  logic [15:0] wdata_in = 16'h0000;
  wire [15:0] rdata_out;
  wire [8:0] modes;
  wire done, stopped, start, run, abort, irq;
  int num_errors = 0, total_checks = 0, starts = 0, irqs = 0;
  logic [15:0] tbl [4] = '{16'h0b1f, 16'h0300, 16'h0325, 16'h0b3a};
  logic [19:0] cfg [6] = '{20'h40100, 20'h50000, 20'h60010, 20'h70004,
    20'h10040, 20'h00800};
  always #10 clk_sys_in = ~clk_sys_in;
  bcs_top bcs_top_inst (.clk_sys_in, .rst_n_in, .idx_wr_in, .idx_data_in,
    .ainc_dis_in, .data_wr_in, .data_rd_in, .wdata_in, .rdata_out,
    .eng_done_in(done), .eng_stopped_in(stopped), .eng_start_out(start),
    .eng_run_out(run), .eng_abort_out(abort), .line_mode_out(modes[8]),
    .y_major_out(modes[7]), .y_up_out(modes[6]), .pat_sel_out(modes[5:4]),
    .mono_tr_out(modes[3]), .tr_opaque_out(modes[2]),
    .tr_src_out(modes[1]), .tr_en_out(modes[0]), .irq_out(irq));
  bcs_engine_model #(.LAT(20)) bcs_engine_model_inst (.clk_sys_in,
    .rst_n_in, .start_in(start), .abort_in(abort), .done_out(done),
    .stopped_out(stopped));
  // Count on the pulse's own rise, well ahead of any check
  always @(posedge start) starts++;
  always @(posedge irq) irqs++;
  // ****************
  // Host port tasks
  // ****************
  // index port, then data port
  task automatic wr(input logic [3:0] i, input logic [15:0] d);
    idx_wr_in = 1;
    idx_data_in = i;
    @(negedge clk_sys_in);
    idx_wr_in = 0;
    data_wr_in = 1;
    wdata_in = d;
    @(negedge clk_sys_in);
    data_wr_in = 0;
  endtask
  // Two edges: index load, then readback refresh
  task automatic seti(input logic [3:0] i);
    idx_wr_in = 1;
    idx_data_in = i;
    @(negedge clk_sys_in);
    idx_wr_in = 0;
    @(negedge clk_sys_in);
  endtask
  task automatic rd(input logic c, input logic [15:0] e);
    if (c) `CHK(rdata_out, e)
    data_rd_in = 1;
    @(negedge clk_sys_in);
    data_rd_in = 0;
    @(negedge clk_sys_in);
  endtask
  task automatic summarize();
    $display("Checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wait_run(input logic val);
    int n;
    for (n = 0; n < 100 && run !== val; n++) @(negedge clk_sys_in);
    if (n == 100) begin
      num_errors++;
      summarize();
    end
  endtask
  function automatic logic [8:0] exp_modes(input logic [15:0] w);
    return {w[11], w[11] & w[9], w[11] & w[8], w[5] ? 2'h0 : w[5:4], w[3:0]};
  endfunction
  initial begin
    repeat (20) @(negedge clk_sys_in);
    rst_n_in = 1;
    @(negedge clk_sys_in);
    foreach (tbl[k]) begin
      wr(4'h1, tbl[k]);
      @(negedge clk_sys_in);
      `CHK(modes, exp_modes(tbl[k]))
    end
    $display("Test modes done");
    wr(4'h1, 16'h0400);
    wr(4'h0, 16'h0800);
    wait_run(1'b1);
    wait_run(1'b0);
    `CHK(irqs, 1)
    seti(4'h0);
    rd(1'b1, 16'h0000);
    foreach (cfg[k]) wr(cfg[k][19:16], cfg[k][15:0]);
    wait_run(1'b1);
    wait_run(1'b0);
    seti(4'h4);
    rd(1'b1, 16'h0110);
    rd(1'b1, 16'h0000);
    `CHK(irqs, 1)
    wr(4'h0, 16'h0880);
    wait_run(1'b1);
    wait_run(1'b0);
    seti(4'h4);
    rd(1'b1, 16'h0150);
    $display("Test update done");
    wr(4'h1, 16'h00c0);
    wr(4'h4, 16'h0200);
    repeat (3) @(negedge clk_sys_in);
    `CHK(starts, 3)
    wr(4'h2, 16'h0000);
    seti(4'h0);
    rd(1'b1, 16'h0880);
    wait_run(1'b0);
    `CHK(starts, 4)
    wr(4'h2, 16'h0000);
    wait_run(1'b1);
    wr(4'h0, 16'h0080);
    repeat (6) @(negedge clk_sys_in);
    seti(4'h4);
    rd(1'b1, 16'h0240);
    wr(4'h1, 16'h0080);
    wr(4'h4, 16'h0300);
    wait_run(1'b1);
    wait_run(1'b0);
    `CHK(starts, 6)
    $display("Test quick done");
    wr(4'he, 16'h5a5a);
    seti(4'he);
    rd(1'b1, 16'h5a5a);
    rd(1'b0, 16'h0000);
    rd(1'b1, 16'h0080);
    ainc_dis_in = 1;
    seti(4'h6);
    rd(1'b1, 16'h0010);
    rd(1'b1, 16'h0010);
    $display("Test index done");
    summarize();
  end
endmodule // bcs_top_tb
